//--- bit_sync.sv
// two-flop level synchroniser, one lane per bit
module bit_sync #(
  parameter int W = 1
) (
  input wire logic clk, // destination clock
  input wire logic rstn, // async reset, active low
  input wire logic [W-1:0] d, // levels from the other domain
  output logic [W-1:0] q // synchronised levels
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;

  sync_s st;
  sync_s next_st;

  // s1 feeds only s2
  always_comb begin
    next_st = st;
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.s2;
endmodule

//--- spi_slave_model.sv
// behavioural slave on the serial clock and data lines
module spi_slave_model (
  input wire logic sck, // serial clock
  input wire logic sdo, // data from master
  input wire logic load, // rising edge loads reply
  input wire logic [15:0] load_word, // reply, msb first
  output logic sdi, // data to master
  output logic [15:0] rx_word // latest bits seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] sh = 16'h0000;
  initial begin
    sdi = 1'b0;
    rx_word = 16'h0000;
  end
  always @(posedge load) begin
    sh = load_word;
  end
  always @(negedge sck) begin
    sdi = sh[15];
    sh = {sh[14:0], 1'b0};
  end
  // once sampled the bit is no longer held, so the line flips
  always @(posedge sck) begin
    rx_word = {rx_word[14:0], sdo};
    #1 sdi = ~sdi;
  end
endmodule

//--- spi_sync_map.svh
// constants for the clock-synchronous serial master
// Function
// R1: three-wire mode never raises mode-fault errors
// R2: frame count 00b: one frame per unit
// R3: access width select 1: byte-wide data accesses
// R4: parity enable 0: no parity sent or checked
// R5: idle irq enable 0: no idle request
// R6: idle/error grouped; receive/transmit lines separate
// R7: data length field 0111b: eight bits
// R8: bit order select 0: msb first
// R9: next delay off: one period plus two cycles
// R10: clock delay off: one period before first edge; the code leads by one and a half periods
// R11: phase 1: change odd edges, sample even
// R12: polarity 1: clock idles high
// R13: division field 10b divides base rate by four
// R14: master select 1: unit drives clock, starts transfers
// R15: mode select 1: clock and data, no select
// R16: software writes only when transmit empty reads 1
// R17: clock = link clock / (2*(brr+1)*2^div)
// R18: function disabled: no transfers, clock idle level; the code still runs a frame already handed to the link to its end
`ifndef SPI_SYNC_MAP_SVH
`define SPI_SYNC_MAP_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define SPI_DW 16
`define SPI_HALF_W 12
`define DLEN_FIELD_8 4'h7
`define DLEN_BITS_8 5'h08

// ----------------------------------------------------------------
// delay counts in half serial clock periods and link clock cycles
// ----------------------------------------------------------------
`define LEAD_HALVES_OFF 3'h2
`define LEAD_HALVES_ON 3'h4
`define NEXT_HALVES_OFF 3'h2
`define NEXT_HALVES_ON 3'h4
`define NEXT_EXTRA_CLK 12'h002

`endif

//--- spi_sync_master.sv
// clock-synchronous three-wire serial master with core and link domains
module spi_sync_master
  import spi_sync_pkg::*;
(
  input wire logic core_clk, // register side clock
  input wire logic link_clk, // shift engine clock, source of serial clock
  input wire logic rstn, // async reset for both domains, active low
  input wire logic function_enable, // unit enable
  input wire logic master_select, // 1: master
  input wire logic three_wire_mode_select, // 1: clock and data only
  input wire logic access_width_select, // 1: byte access to data register
  input wire logic parity_enable, // 1: append and check parity
  input wire logic idle_irq_enable, // idle request enable
  input wire logic error_irq_enable, // error request enable
  input wire logic rx_irq_enable, // receive-full request enable
  input wire logic tx_irq_enable, // transmit-empty request enable
  input wire logic [3:0] data_length_field, // data bits minus one, values below 0111b give eight
  input wire logic bit_order_select, // 1: lsb first
  input wire logic next_access_delay_enable, // 1: longer gap between frames
  input wire logic clock_delay_enable, // 1: longer lead before first edge
  input wire logic clock_phase, // 1: change odd, sample even edges
  input wire logic clock_polarity, // 1: clock idles high
  input wire logic [1:0] bit_rate_division, // divide base rate by 2^n
  input wire logic [7:0] bit_rate_register, // base rate divider value
  input wire logic data_write, // write strobe to data register
  input wire logic [`SPI_DW-1:0] write_data, // data for write strobe
  input wire logic data_read, // read strobe, clears receive-full
  input wire logic error_clear, // clears overrun and parity flags
  input wire logic serial_data_in, // data from slave, asynchronous
  output logic [`SPI_DW-1:0] read_data, // data captured by last read strobe
  output logic transmit_buffer_empty_flag, // data register may be written
  output logic receive_full_flag, // received word waiting
  output logic overrun_flag, // word lost while receive-full
  output logic parity_error_flag, // parity mismatch seen
  output logic busy, // transfer handed to link, not yet answered
  output logic receive_full_irq, // receive-full request line
  output logic transmit_empty_irq, // transmit-empty request line
  output logic group_irq, // idle and error requests combined
  output logic serial_clock_line, // serial clock to slave
  output logic serial_data_out // serial data to slave
);
`include "spi_sync_map.svh"

  // ----------------------------------------------------------------
  // state and crossings
  // ----------------------------------------------------------------
  core_s st;
  core_s next_st;
  link_s lk;
  link_s next_lk;
  logic ack_s;
  logic [2:0] link_in_s;

  // tx_stage and cfg stay frozen while a request is open, so the link
  // may read them as soon as it sees the toggle; rx likewise for ack
  // one level change per frame on each toggle, so neither clock ratio
  // can lose or double a request
  // the pin, the idle polarity and the request ride one synchroniser
  bit_sync #(
    .W(1)
  ) u_ack_sync (
    .clk(core_clk),
    .rstn(rstn),
    .d(lk.ack_tog),
    .q(ack_s)
  );

  bit_sync #(
    .W(3)
  ) u_link_sync (
    .clk(link_clk),
    .rstn(rstn),
    .d({st.req_tog, clock_polarity, serial_data_in}),
    .q(link_in_s)
  );

  // ----------------------------------------------------------------
  // frame bit selection
  // ----------------------------------------------------------------
  function automatic logic tx_bit(input logic [`SPI_DW-1:0] d, input cfg_s c,
                                  input logic [4:0] k);
    logic [`SPI_DW-1:0] m;
    logic [4:0] idx;
    logic p;
    begin
      m = 16'hFFFF >> (5'h10 - c.data_bits);
      p = ^(d & m);
      if (c.lsb_first) begin
        idx = k;
      end else begin
        idx = c.data_bits - 5'h01 - k; // [R8]
      end
      // positions past the data width carry the even parity bit
      tx_bit = (k >= c.data_bits) ? p : d[idx[3:0]];
    end
  endfunction

  // ----------------------------------------------------------------
  // core domain: data register, flags, request lines
  // ----------------------------------------------------------------
  logic go;
  logic inflight;
  logic ack_new;
  logic rx_held;
  cfg_s nc;

  always_comb begin
    next_st = st;
    nc = st.cfg;
    inflight = st.req_tog != st.ack_seen;
    ack_new = ack_s != st.ack_seen;
    rx_held = st.rx_full & ~data_read;
    go = function_enable & master_select & three_wire_mode_select; // [R14] [R15] [R18]

    if (clock_phase) begin
      nc.cpha = 1'b1; // [R11]
    end else begin
      nc.cpha = 1'b0;
    end
    if (data_length_field < `DLEN_FIELD_8) begin
      nc.data_bits = `DLEN_BITS_8;
    end else begin
      nc.data_bits = {1'b0, data_length_field} + 5'h01; // [R7]
    end
    nc.lsb_first = bit_order_select; // [R8]
    nc.cpol = clock_polarity; // [R12]
    nc.parity_en = parity_enable; // [R4]
    nc.half = ({4'h0, bit_rate_register} + 12'h001) << bit_rate_division; // [R13] [R17]
    if (clock_delay_enable) begin
      nc.lead_halves = `LEAD_HALVES_ON;
    end else begin
      nc.lead_halves = `LEAD_HALVES_OFF; // [R10]
    end
    if (next_access_delay_enable) begin
      nc.next_halves = `NEXT_HALVES_ON;
    end else begin
      nc.next_halves = `NEXT_HALVES_OFF; // [R9]
    end

    // hand the staged word to the link only when nothing is open
    if (!st.tx_empty && !inflight && go) begin
      next_st.tx_stage = st.tx_data;
      next_st.cfg = nc;
      next_st.req_tog = ~st.req_tog;
      next_st.tx_empty = 1'b1; // [R2]
      next_st.idle_flag = 1'b0;
    end

    // a write while not empty overwrites the staged word
    if (data_write) begin
      if (access_width_select) begin
        next_st.tx_data = {8'h00, write_data[7:0]}; // [R3]
      end else begin
        next_st.tx_data = write_data;
      end
      next_st.tx_empty = 1'b0;
      next_st.idle_flag = 1'b0;
    end

    if (data_read) begin
      if (access_width_select) begin
        next_st.rd_data = {8'h00, st.rx_data[7:0]}; // [R3]
      end else begin
        next_st.rd_data = st.rx_data;
      end
      next_st.rx_full = 1'b0;
    end

    if (error_clear) begin
      next_st.overrun = 1'b0;
      next_st.perr = 1'b0;
    end

    // answers set after the clears so a same-cycle event wins
    if (ack_new) begin
      next_st.ack_seen = ack_s;
      if (rx_held) begin
        next_st.overrun = 1'b1;
      end else begin
        next_st.rx_data = lk.rx;
        next_st.rx_full = 1'b1; // [R2]
      end
      if (lk.perr && st.cfg.parity_en) begin
        next_st.perr = 1'b1; // [R4]
      end
      if (st.tx_empty && !data_write) begin
        next_st.idle_flag = 1'b1;
      end
    end

    // request lines are registered levels, one cycle behind their enables
    next_st.busy = next_st.req_tog != next_st.ack_seen;
    next_st.rfi = next_st.rx_full & rx_irq_enable; // [R6]
    next_st.tei = next_st.tx_empty & tx_irq_enable & function_enable; // [R6]
    // no slave-select input exists, so no mode-fault source feeds this
    next_st.gi = (next_st.idle_flag & idle_irq_enable) // [R5] [R6]
               | ((next_st.overrun | next_st.perr) & error_irq_enable); // [R1]
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      // empty resets high so the first word may be written at once
      st <= '0;
      st.tx_empty <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // link domain: clock generation and shifting
  // ----------------------------------------------------------------
  logic req_new;
  logic tick;
  logic odd_edge;
  logic sd;
  logic [4:0] nb;
  logic [4:0] ridx;

  // a frame that loses its enable midway still runs to its end
  always_comb begin
    next_lk = lk;
    sd = link_in_s[0];
    req_new = link_in_s[2] != lk.req_seen;
    tick = lk.cnt == 12'h001;
    odd_edge = ~lk.edge_n[0];
    nb = lk.cfg.data_bits + {4'h0, lk.cfg.parity_en}; // [R4]
    if (lk.cfg.lsb_first) begin
      ridx = lk.bitk;
    end else begin
      ridx = lk.cfg.data_bits - 5'h01 - lk.bitk; // [R8]
    end

    if (tick) begin
      next_lk.cnt = lk.cfg.half; // [R17]
    end else begin
      next_lk.cnt = lk.cnt - 12'h001;
    end

    case (lk.state)
      LINK_IDLE: begin
        next_lk.sck = link_in_s[1]; // [R12] [R18]
        if (req_new) begin
          next_lk.state = LINK_LEAD;
          next_lk.cfg = st.cfg;
          next_lk.tx = st.tx_stage;
          next_lk.req_seen = link_in_s[2];
          next_lk.cnt = st.cfg.half;
          next_lk.halves = st.cfg.lead_halves; // [R10]
          next_lk.edge_n = 6'h00;
          next_lk.bitk = 5'h00;
          next_lk.rx = '0;
          next_lk.par = 1'b0;
          next_lk.perr = 1'b0;
          next_lk.sck = st.cfg.cpol; // [R12]
          // phase 0 shows the first bit before the first edge
          if (!st.cfg.cpha) begin
            next_lk.sdo = tx_bit(st.tx_stage, st.cfg, 5'h00);
          end
        end
      end
      LINK_LEAD: begin
        // clock parked at idle while whole halves count down
        next_lk.sck = lk.cfg.cpol;
        if (tick) begin
          next_lk.halves = lk.halves - 3'h1;
          if (lk.halves == 3'h1) begin
            next_lk.state = LINK_SHIFT; // [R10]
          end
        end
      end
      LINK_SHIFT: begin
        if (tick) begin
          next_lk.sck = ~lk.sck;
          next_lk.edge_n = lk.edge_n + 6'h01;
          if (odd_edge == lk.cfg.cpha) begin
            // drive edge: odd for phase 1, even for phase 0
            if (lk.bitk < nb) begin
              next_lk.sdo = tx_bit(lk.tx, lk.cfg, lk.bitk); // [R11]
            end
          end else begin
            // sample edge; sd lags the pin by two link cycles
            if (lk.bitk < lk.cfg.data_bits) begin
              next_lk.rx[ridx[3:0]] = sd; // [R11]
              next_lk.par = lk.par ^ sd;
            end else begin
              next_lk.perr = lk.par ^ sd; // [R4]
            end
            next_lk.bitk = lk.bitk + 5'h01;
          end
          // an even edge count leaves the clock at its idle level
          if (next_lk.edge_n == {nb, 1'b0}) begin
            next_lk.state = LINK_NEXT;
            next_lk.ack_tog = ~lk.ack_tog; // [R2]
            next_lk.halves = lk.cfg.next_halves; // [R9]
          end
        end
      end
      LINK_NEXT: begin
        next_lk.sck = lk.cfg.cpol;
        if (tick) begin
          if (lk.halves == 3'h0) begin
            next_lk.state = LINK_IDLE;
          end else begin
            next_lk.halves = lk.halves - 3'h1;
            // two spare link cycles follow the last half
            if (lk.halves == 3'h1) begin
              next_lk.cnt = `NEXT_EXTRA_CLK; // [R9]
            end
          end
        end
      end
      default: begin
        next_lk.state = LINK_IDLE;
      end
    endcase
  end

  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      lk <= '0;
    end else begin
      lk <= next_lk;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------------------------------
  // the serial pins change only on link edges, never on core edges
  assign read_data = st.rd_data;
  assign transmit_buffer_empty_flag = st.tx_empty;
  assign receive_full_flag = st.rx_full;
  assign overrun_flag = st.overrun;
  assign parity_error_flag = st.perr;
  assign busy = st.busy;
  assign receive_full_irq = st.rfi;
  assign transmit_empty_irq = st.tei;
  assign group_irq = st.gi;
  assign serial_clock_line = lk.sck;
  assign serial_data_out = lk.sdo;
endmodule

//--- spi_sync_master_checker.sv
// port assertions for the clock-synchronous serial master
`include "spi_sync_map.svh"
module spi_sync_master_checker (
  input wire logic core_clk, // core clock
  input wire logic link_clk, // link clock
  input wire logic rstn, // reset, low
  input wire logic function_enable, // enable
  input wire logic access_width_select, // byte mode
  input wire logic idle_irq_enable, // idle en
  input wire logic error_irq_enable, // error en
  input wire logic rx_irq_enable, // rx en
  input wire logic clock_phase, // phase
  input wire logic [1:0] bit_rate_division, // shift
  input wire logic [7:0] bit_rate_register, // base
  input wire logic data_read, // read strobe
  input wire logic [`SPI_DW-1:0] read_data, // read word
  input wire logic overrun_flag, // overrun
  input wire logic parity_error_flag, // parity
  input wire logic busy, // pending
  input wire logic receive_full_irq, // rx line
  input wire logic group_irq, // group line
  input wire logic serial_clock_line, // sck
  input wire logic serial_data_out // sdo
);
  logic [11:0] low_cnt;
  logic seen;
  wire [11:0] half_w = ({4'h0, bit_rate_register} + 12'h001) << bit_rate_division;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // seen masks the reset-time low phase, which is not a half period
  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      low_cnt <= 12'h000;
      seen <= 1'b0;
    end else begin
      low_cnt <= serial_clock_line ? 12'h000 : low_cnt + 12'h001;
      seen <= seen | serial_clock_line;
    end
  end
  AST_HALF_LOW: assert property (@(posedge link_clk) disable iff (!rstn)
    $rose(serial_clock_line) && seen |-> low_cnt == half_w) else $error("low phase length");
  AST_DATA_LOW: assert property (@(posedge link_clk) disable iff (!rstn)
    clock_phase && $changed(serial_data_out) |-> !serial_clock_line) else $error("data edge");
  AST_DIS_STILL: assert property (@(posedge link_clk) disable iff (!rstn)
    !function_enable [*8] |-> $stable(serial_clock_line)) else $error("clock moved");
  AST_NO_FAULT: assert property (@(posedge core_clk) disable iff (!rstn)
    (!idle_irq_enable && !overrun_flag && !parity_error_flag) [*2] |-> !group_irq)
    else $error("group request without cause");
  AST_IDLE_MASK: assert property (@(posedge core_clk) disable iff (!rstn)
    (!idle_irq_enable && !error_irq_enable) [*2] |-> !group_irq) else $error("idle unmasked");
  AST_RX_MASK: assert property (@(posedge core_clk) disable iff (!rstn)
    !rx_irq_enable [*2] |-> !receive_full_irq) else $error("rx line unmasked");
  AST_BYTE_READ: assert property (@(posedge core_clk) disable iff (!rstn)
    data_read && access_width_select |=> read_data[15:8] == 8'h00) else $error("byte read");
  AST_NO_LAUNCH: assert property (@(posedge core_clk) disable iff (!rstn)
    !function_enable && !busy |=> !busy) else $error("launch while disabled");
  cover property (@(posedge core_clk) $rose(overrun_flag));
  cover property (@(posedge core_clk) $rose(parity_error_flag));
  cover property (@(posedge core_clk) $rose(group_irq));
endmodule

bind spi_sync_master spi_sync_master_checker u_spi_sync_master_checker (
  .core_clk(core_clk), .link_clk(link_clk), .rstn(rstn), .function_enable(function_enable),
  .access_width_select(access_width_select), .idle_irq_enable(idle_irq_enable),
  .error_irq_enable(error_irq_enable), .rx_irq_enable(rx_irq_enable),
  .clock_phase(clock_phase), .bit_rate_division(bit_rate_division),
  .bit_rate_register(bit_rate_register), .data_read(data_read), .read_data(read_data),
  .overrun_flag(overrun_flag), .parity_error_flag(parity_error_flag), .busy(busy),
  .receive_full_irq(receive_full_irq), .group_irq(group_irq),
  .serial_clock_line(serial_clock_line), .serial_data_out(serial_data_out)
);

//--- spi_sync_pkg.sv
// types shared by the clock-synchronous serial master
package spi_sync_pkg;
`include "spi_sync_map.svh"

  typedef enum logic [1:0] {
    LINK_IDLE = 2'b00,
    LINK_LEAD = 2'b01,
    LINK_SHIFT = 2'b10,
    LINK_NEXT = 2'b11
  } link_state_e;

  typedef struct packed {
    logic [4:0] data_bits;
    logic lsb_first;
    logic cpha;
    logic cpol;
    logic parity_en;
    logic [`SPI_HALF_W-1:0] half;
    logic [2:0] lead_halves;
    logic [2:0] next_halves;
  } cfg_s;

  typedef struct packed {
    logic [`SPI_DW-1:0] tx_data;
    logic tx_empty;
    logic [`SPI_DW-1:0] tx_stage;
    cfg_s cfg;
    logic req_tog;
    logic ack_seen;
    logic [`SPI_DW-1:0] rx_data;
    logic rx_full;
    logic overrun;
    logic perr;
    logic idle_flag;
    logic [`SPI_DW-1:0] rd_data;
    logic busy;
    logic rfi;
    logic tei;
    logic gi;
  } core_s;

  typedef struct packed {
    link_state_e state;
    cfg_s cfg;
    logic [`SPI_DW-1:0] tx;
    logic [`SPI_DW-1:0] rx;
    logic req_seen;
    logic ack_tog;
    logic [`SPI_HALF_W-1:0] cnt;
    logic [2:0] halves;
    logic [5:0] edge_n;
    logic [4:0] bitk;
    logic par;
    logic perr;
    logic sck;
    logic sdo;
  } link_s;

endpackage

//--- tb_spi_sync_master.sv
// self-checking bench for the clock-synchronous serial master
module tb_spi_sync_master;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int H = 24; // (5 + 1) << 2 link cycles
  logic core_clk = 1'b0, link_clk = 1'b0, rstn = 1'b0, en = 1'b1, pe = 1'b0, iie = 1'b0;
  logic eie = 1'b0, rie = 1'b1, tie = 1'b1, lsb = 1'b0, nde = 1'b0, cde = 1'b0;
  logic wr = 1'b0, rd = 1'b0, eclr = 1'b0, ld = 1'b0, ms = 1'b1, sdi, sck_q;
  logic [3:0] dlen = 4'h7;
  logic [1:0] div = 2'h2;
  logic [7:0] brr = 8'h05;
  logic [15:0] wdat = 16'h0000, sw = 16'h0000, rdat, srx;
  logic txe, rxf, ovr, perr, busy, rxi, txi, gi, sck, sdo;
  int err_count = 0, tests_run = 0, cyc = 0, hi_run = 0, falls = 0;
  int gaps[$];
  spi_sync_master u_spi_sync_master (
    .core_clk(core_clk), .link_clk(link_clk), .rstn(rstn), .function_enable(en),
    .master_select(ms), .three_wire_mode_select(1'b1), .access_width_select(1'b1),
    .parity_enable(pe), .idle_irq_enable(iie), .error_irq_enable(eie), .rx_irq_enable(rie),
    .tx_irq_enable(tie), .data_length_field(dlen), .bit_order_select(lsb),
    .next_access_delay_enable(nde), .clock_delay_enable(cde), .clock_phase(1'b1),
    .clock_polarity(1'b1), .bit_rate_division(div), .bit_rate_register(brr),
    .data_write(wr), .write_data(wdat), .data_read(rd), .error_clear(eclr),
    .serial_data_in(sdi), .read_data(rdat), .transmit_buffer_empty_flag(txe),
    .receive_full_flag(rxf), .overrun_flag(ovr), .parity_error_flag(perr), .busy(busy),
    .receive_full_irq(rxi), .transmit_empty_irq(txi), .group_irq(gi),
    .serial_clock_line(sck), .serial_data_out(sdo));
  spi_slave_model u_spi_slave_model (.sck(sck), .sdo(sdo), .load(ld), .load_word(sw),
    .sdi(sdi), .rx_word(srx));
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    #1.3;
    forever #3 link_clk = ~link_clk;
  end
  // high stretch before every falling serial clock edge
  always @(posedge link_clk) begin
    sck_q <= sck;
    hi_run <= sck ? hi_run + 1 : 0;
    if (sck_q === 1'b1 && sck === 1'b0) begin
      falls <= falls + 1;
      gaps.push_back(hi_run);
    end
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      report_and_stop();
    end
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    if (err_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic arm(input logic [15:0] reply);
    sw = reply;
    gaps.delete();
    falls = 0;
    ld = 1'b1;
    tick(1);
    ld = 1'b0;
  endtask
  task automatic put(input logic [15:0] d);
    for (int i = 0; i < 2000 && txe !== 1'b1; i++) tick(1);
    wdat = d;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
    tick(1);
  endtask
  task automatic wait_rx();
    for (int i = 0; i < 4000 && rxf !== 1'b1; i++) tick(1);
    chk("receive_full_flag", 1, rxf);
  endtask
  task automatic send(input logic [15:0] d, input logic [15:0] reply);
    arm(reply);
    put(d);
    wait_rx();
  endtask
  task automatic pulse_clr();
    eclr = 1'b1;
    tick(1);
    eclr = 1'b0;
    tick(2);
  endtask
  task automatic rd_chk(input logic [15:0] exp);
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    tick(1);
    chk("read_data", exp, rdat);
  endtask
  task automatic chk_halves(input int h);
    for (int i = 1; i < 8; i++) chk("half_period", 16'(h), 16'(gaps[i]));
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk("flags", 16'h0020, {txe, busy, rxf, ovr, perr, gi});
    chk("serial_clock_line", 1, sck);
  endtask
  task automatic t_basic();
    send(16'h00A5, 16'h3C00);
    chk("edges", 8, 16'(falls));
    chk("slave_rx", 16'h00A5, {8'h00, srx[7:0]});
    chk_halves(H);
    chk("irq_lines", 16'h0006, {rxi, txi, gi});
    rd_chk(16'h003C);
    chk("serial_clock_line", 1, sck);
  endtask
  task automatic t_lsb();
    lsb = 1'b1;
    dlen = 4'h3;
    brr = 8'h02;
    div = 2'h1;
    send(16'h001E, 16'hB400);
    chk("edges", 8, 16'(falls));
    chk("slave_rx", 16'h0078, {8'h00, srx[7:0]});
    chk_halves(6);
    rd_chk(16'h002D);
    lsb = 1'b0;
    dlen = 4'h7;
    brr = 8'h05;
    div = 2'h2;
  endtask
  task automatic t_parity();
    pe = 1'b1;
    eie = 1'b1;
    rie = 1'b0;
    tie = 1'b0;
    send(16'h005A, 16'hC380);
    chk("edges", 9, 16'(falls));
    chk("slave_rx", 16'h00B4, {7'h00, srx[8:0]});
    chk("err_lines", 16'h000C, {perr, gi, rxi, txi});
    pulse_clr();
    chk("err_lines", 0, {perr, gi});
    rd_chk(16'h00C3);
    pe = 1'b0;
    send(16'h005A, 16'hC380);
    chk("edges", 8, 16'(falls));
    chk("parity_error_flag", 0, perr);
    rd_chk(16'h00C3);
    eie = 1'b0;
    rie = 1'b1;
    tie = 1'b1;
  endtask
  task automatic t_gap(input int lo);
    arm(16'h9966);
    put(16'h0011);
    put(16'h0022);
    for (int i = 0; i < 8000 && (falls < 16 || busy !== 1'b0); i++) tick(1);
    tick(2);
    chk("gap_in_range", 1, 16'(gaps[8] >= lo && gaps[8] <= lo + 4));
    chk("slave_rx", 16'h1122, srx);
    chk("overrun_no_irq", 16'h0002, {ovr, gi});
    pulse_clr();
    rd_chk(16'h0099);
  endtask
  task automatic t_idle();
    iie = 1'b1;
    send(16'h0001, 16'h0100);
    tick(2);
    chk("group_irq", 1, gi);
    iie = 1'b0;
    tick(2);
    chk("group_irq", 0, gi);
    rd_chk(16'h0001);
  endtask
  task automatic t_off();
    en = 1'b0;
    arm(16'h4200);
    put(16'h0033);
    tick(300);
    chk("edges", 0, 16'(falls));
    chk("serial_clock_line", 1, sck);
    ms = 1'b0;
    en = 1'b1;
    tick(300);
    chk("edges", 0, 16'(falls));
    chk("busy", 0, busy);
    ms = 1'b1;
    wait_rx();
    rd_chk(16'h0042);
  endtask
  initial begin
    repeat (16) @(negedge core_clk);
    rstn = 1'b1;
    tick(10);
    t_reset();
    t_basic();
    t_lsb();
    t_parity();
    t_gap(5 * H);
    nde = 1'b1;
    cde = 1'b1;
    t_gap(9 * H);
    t_idle();
    t_off();
    report_and_stop();
  end
endmodule
